// [hw/dhsc_pkg.sv]
package dhsc_pkg;

  // ---------------------------------------------------------------
  // Clocking
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned REF_HZ = 10_000_000;
  localparam int unsigned REF_DIV = CLK_HZ / REF_HZ;

  // ---------------------------------------------------------------
  // Pulse outputs
  // ---------------------------------------------------------------
  localparam logic [14:0] DUTY_FULL = 15'h7D00;
  localparam logic [11:0] DUTY_SCALE = 12'(CLK_HZ / 32000);
  localparam logic [26:0] PHASE_WRAP = 27'(CLK_HZ);
  localparam logic [26:0] PHASE_RST = 27'h0000000;

  // ---------------------------------------------------------------
  // Frequency measurement time base
  // ---------------------------------------------------------------
  localparam int unsigned FREQ_BASE_MS = 1000;
  localparam int unsigned FREQ_BASE_CYCLES = (CLK_HZ / 1000) * FREQ_BASE_MS;

  // ---------------------------------------------------------------
  // Input filter limits, minimum stable cycles per half period
  // ---------------------------------------------------------------
  localparam int unsigned FILT_500K_HZ = 500_000;
  localparam int unsigned FILT_100K_HZ = 100_000;
  localparam int unsigned FILT_50K_HZ = 50_000;
  localparam logic [9:0] FILT_OFF_CYC = 10'h001;
  localparam logic [9:0] FILT_500K_CYC = 10'(CLK_HZ / (2 * FILT_500K_HZ));
  localparam logic [9:0] FILT_100K_CYC = 10'(CLK_HZ / (2 * FILT_100K_HZ));
  localparam logic [9:0] FILT_50K_CYC = 10'(CLK_HZ / (2 * FILT_50K_HZ));

  localparam logic [31:0] C1_MAX = 32'hFFFFFFFF;
  localparam logic [15:0] C2_MAX = 16'hFFFF;

  typedef enum logic [2:0] {
    MODE_INTERNAL, MODE_UP, MODE_DOWN, MODE_UPDN, MODE_CLKDIR_IN, MODE_CLKDIR_Q, MODE_QUAD
  } dhsc_mode_e;

  typedef enum logic [2:0] {
    SRC_NONE, SRC_IN1, SRC_IN2, SRC_IN3, SRC_OVF, SRC_UNF, SRC_Q
  } dhsc_src_e;

  typedef enum logic [1:0] {
    POL_HIGH, POL_LOW, POL_FALL, POL_RISE
  } dhsc_pol_e;

  typedef enum logic [1:0] {
    FILT_OFF, FILT_500K, FILT_100K, FILT_50K
  } dhsc_filt_e;

endpackage

// [hw/dhsc_filter.sv]
`timescale 1ns/1ps
module dhsc_filter (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [2:0] raw_i,
  input wire dhsc_pkg::dhsc_filt_e sel_i [3],
  output logic [2:0] filt_o
);

  // ---------------------------------------------------------------
  // Per-input glitch filter
  // ---------------------------------------------------------------
  // A new level is accepted only after it has held for the chosen
  // half period, so faster toggling never reaches the counters.
  for (genvar i = 0; i < 3; i++)
  begin : g_in
    logic [9:0] cnt;
    logic [9:0] lim;

    always_comb
    begin
      unique case (sel_i[i])
        dhsc_pkg::FILT_OFF: lim = dhsc_pkg::FILT_OFF_CYC;
        dhsc_pkg::FILT_500K: lim = dhsc_pkg::FILT_500K_CYC;
        dhsc_pkg::FILT_100K: lim = dhsc_pkg::FILT_100K_CYC;
        dhsc_pkg::FILT_50K: lim = dhsc_pkg::FILT_50K_CYC;
      endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
      if (!nrst_i)
      begin
        cnt <= 10'h000;
        filt_o[i] <= 1'b0;
      end
      else if (raw_i[i] == filt_o[i])
      begin
        cnt <= 10'h000;
      end
      else if (cnt + 10'h001 >= lim)
      begin
        cnt <= 10'h000;
        filt_o[i] <= raw_i[i];
      end
      else
      begin
        cnt <= cnt + 10'h001;
      end
    end
  end

endmodule

// [hw/dhsc_top.sv]
`timescale 1ns/1ps
// What this block does
// - Duty word scales linearly; 16000 gives half high time, 8000 a quarter.
// - Frequency word sets the pulse output frequency directly in hertz.
// - Each pulse channel drives logic-level and 24 V outputs together.
// - Counter one is a 32-bit totalizer or a frequency counter.
// - Counter two is a 16-bit totalizer only, no frequency mode.
// - Internal mode counts on a 10 MHz reference tick.
// - Count-up and count-down modes count pulses on inputs 1 and 2.
// - Up/down mode: input 1 counts up, input 2 counts down.
// - Clock/direction mode: input 1 clocks, input 2 gives direction.
// - Second clock/direction mode takes direction from a program bit.
// - Quadrature mode decodes two phase-shifted inputs into signed counts.
// - Frequency mode reports counts per selected period; one second gives hertz.
// - Disable halts counting while asserted; level sensitivity only.
// - Latch trigger copies the accumulator into a holding register.
// - Preload trigger loads the stored value; not in frequency mode.
// - Clear trigger zeroes the accumulator; not in frequency mode.
// - Trigger source is none, input 1-3, overflow, underflow or program bit.
// - Overflow fires on wrap past maximum, underflow on going below zero.
// - Latch, preload, clear accept high, low, falling or rising sensitivity.
// - Each input has a selectable filter rejecting faster toggling.
// - Counter two offers only the clear function.
// - Both counters run at once with separate configurations.
// - Duty word spans 0 to 32000; 32000 means always high.
// - Frequency word zero hands the output to manual on/off control.
// - Program direction bit: 1 counts up, 0 counts down.
// - Overflow and underflow flags stay set until the reset bit is written.
module dhsc_top #(
  parameter int unsigned FREQ_BASE_CYCLES = dhsc_pkg::FREQ_BASE_CYCLES
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ext1_i,
  input wire logic ext2_i,
  input wire logic ext3_i,
  input wire dhsc_pkg::dhsc_filt_e ext1_filt_i,
  input wire dhsc_pkg::dhsc_filt_e ext2_filt_i,
  input wire dhsc_pkg::dhsc_filt_e ext3_filt_i,
  input wire logic c1_freq_mode_i,
  input wire dhsc_pkg::dhsc_mode_e c1_mode_i,
  input wire logic [1:0] c1_period_sel_i,
  input wire dhsc_pkg::dhsc_src_e c1_dis_src_i,
  input wire dhsc_pkg::dhsc_pol_e c1_dis_pol_i,
  input wire dhsc_pkg::dhsc_src_e c1_lat_src_i,
  input wire dhsc_pkg::dhsc_pol_e c1_lat_pol_i,
  input wire dhsc_pkg::dhsc_src_e c1_pre_src_i,
  input wire dhsc_pkg::dhsc_pol_e c1_pre_pol_i,
  input wire dhsc_pkg::dhsc_src_e c1_clr_src_i,
  input wire dhsc_pkg::dhsc_pol_e c1_clr_pol_i,
  input wire logic c1_dis_q_i,
  input wire logic c1_lat_q_i,
  input wire logic c1_pre_q_i,
  input wire logic c1_clr_q_i,
  input wire logic c1_dir_q_i,
  input wire logic [31:0] c1_preload_i,
  input wire logic flag_reset_i,
  input wire dhsc_pkg::dhsc_mode_e c2_mode_i,
  input wire dhsc_pkg::dhsc_src_e c2_clr_src_i,
  input wire dhsc_pkg::dhsc_pol_e c2_clr_pol_i,
  input wire logic c2_clr_q_i,
  input wire logic c2_dir_q_i,
  input wire logic [14:0] pwm1_duty_i,
  input wire logic [15:0] pwm1_freq_i,
  input wire logic pwm1_manual_i,
  input wire logic [14:0] pwm2_duty_i,
  input wire logic [15:0] pwm2_freq_i,
  input wire logic pwm2_manual_i,
  output logic [2:0] ext_state_o,
  output logic [31:0] c1_count_o,
  output logic [31:0] c1_latch_o,
  output logic c1_ovf_flag_o,
  output logic c1_unf_flag_o,
  output logic [15:0] c2_count_o,
  output logic first_pulse_output_ttl_o,
  output logic first_pulse_output_hv_o,
  output logic second_pulse_output_ttl_o,
  output logic second_pulse_output_hv_o
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic trig_hit(input dhsc_pkg::dhsc_src_e src,
                                    input dhsc_pkg::dhsc_pol_e pol,
                                    input logic [6:0] now,
                                    input logic [6:0] prev);
    logic s;
    logic p;
    logic hit;
    s = now[src];
    p = prev[src];
    unique case (pol)
      dhsc_pkg::POL_HIGH: hit = s;
      dhsc_pkg::POL_LOW: hit = !s;
      dhsc_pkg::POL_FALL: hit = p && !s;
      dhsc_pkg::POL_RISE: hit = !p && s;
    endcase
    return hit && (src != dhsc_pkg::SRC_NONE);
  endfunction

  // Returns {up, down}; a simultaneous up and down cancels out.
  function automatic logic [1:0] step(input dhsc_pkg::dhsc_mode_e mode,
                                      input logic [2:0] f,
                                      input logic [2:0] fp,
                                      input logic tick,
                                      input logic dirq);
    logic r1;
    logic r2;
    logic ch;
    logic up;
    logic dn;
    r1 = f[0] && !fp[0];
    r2 = f[1] && !fp[1];
    ch = (f[0] ^ fp[0]) || (f[1] ^ fp[1]);
    up = 1'b0;
    dn = 1'b0;
    unique case (mode)
      dhsc_pkg::MODE_INTERNAL: up = tick;
      dhsc_pkg::MODE_UP: up = r1 || r2;
      dhsc_pkg::MODE_DOWN: dn = r1 || r2;
      dhsc_pkg::MODE_UPDN:
      begin
        up = r1;
        dn = r2;
      end
      dhsc_pkg::MODE_CLKDIR_IN:
      begin
        up = r1 && f[1];
        dn = r1 && !f[1];
      end
      dhsc_pkg::MODE_CLKDIR_Q:
      begin
        up = r1 && dirq;
        dn = r1 && !dirq;
      end
      dhsc_pkg::MODE_QUAD:
      begin
        up = ch && (f[0] ^ fp[1]);
        dn = ch && (f[1] ^ fp[0]);
      end
      default:
      begin
        up = 1'b0;
        dn = 1'b0;
      end
    endcase
    return (up && dn) ? 2'h0 : {up, dn};
  endfunction

  // ---------------------------------------------------------------
  // Inputs and reference tick
  // ---------------------------------------------------------------
  logic [2:0] filt;
  logic [2:0] filt_prev;
  logic [4:0] q_prev;
  logic [3:0] ref_cnt;
  logic ref_tick;
  dhsc_pkg::dhsc_filt_e filt_sel [3];

  assign filt_sel[0] = ext1_filt_i;
  assign filt_sel[1] = ext2_filt_i;
  assign filt_sel[2] = ext3_filt_i;

  dhsc_filter u_filter (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .raw_i({ext3_i, ext2_i, ext1_i}),
    .sel_i(filt_sel),
    .filt_o(filt)
  );

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      filt_prev <= 3'h0;
      q_prev <= 5'h00;
      ext_state_o <= 3'h0;
    end
    else
    begin
      filt_prev <= filt;
      q_prev <= {c2_clr_q_i, c1_clr_q_i, c1_pre_q_i, c1_lat_q_i, c1_dis_q_i};
      ext_state_o <= filt;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ref_cnt <= 4'h0;
      ref_tick <= 1'b0;
    end
    else
    begin
      ref_tick <= (ref_cnt == 4'(dhsc_pkg::REF_DIV - 1));
      ref_cnt <= (ref_cnt == 4'(dhsc_pkg::REF_DIV - 1)) ? 4'h0 : ref_cnt + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // Counter one
  // ---------------------------------------------------------------
  logic c1_ovf_p;
  logic c1_unf_p;
  logic c1_ovf_pp;
  logic c1_unf_pp;
  logic [5:0] c1_com;
  logic [5:0] c1_com_prev;
  logic c1_dis_hit;
  logic c1_lat_hit;
  logic c1_pre_hit;
  logic c1_clr_hit;
  logic [1:0] c1_step;
  logic c1_run;
  logic [31:0] c1_pulses;
  logic [26:0] c1_win;
  logic [26:0] c1_win_len;

  assign c1_com = {c1_unf_p, c1_ovf_p, filt, 1'b0};
  assign c1_com_prev = {c1_unf_pp, c1_ovf_pp, filt_prev, 1'b0};
  // Disable knows only levels; an edge code falls back to its level.
  assign c1_dis_hit = trig_hit(c1_dis_src_i, (c1_dis_pol_i == dhsc_pkg::POL_LOW ||
                               c1_dis_pol_i == dhsc_pkg::POL_FALL) ? dhsc_pkg::POL_LOW :
                               dhsc_pkg::POL_HIGH, {c1_dis_q_i, c1_com},
                               {q_prev[0], c1_com_prev});
  assign c1_lat_hit = trig_hit(c1_lat_src_i, c1_lat_pol_i, {c1_lat_q_i, c1_com},
                               {q_prev[1], c1_com_prev});
  assign c1_pre_hit = trig_hit(c1_pre_src_i, c1_pre_pol_i, {c1_pre_q_i, c1_com},
                               {q_prev[2], c1_com_prev}) && !c1_freq_mode_i;
  assign c1_clr_hit = trig_hit(c1_clr_src_i, c1_clr_pol_i, {c1_clr_q_i, c1_com},
                               {q_prev[3], c1_com_prev}) && !c1_freq_mode_i;
  assign c1_step = step(c1_mode_i, filt, filt_prev, ref_tick, c1_dir_q_i);
  assign c1_run = !c1_dis_hit;

  always_comb
  begin
    unique case (c1_period_sel_i)
      2'h0: c1_win_len = 27'(FREQ_BASE_CYCLES);
      2'h1: c1_win_len = 27'(FREQ_BASE_CYCLES / 10);
      2'h2: c1_win_len = 27'(FREQ_BASE_CYCLES / 100);
      2'h3: c1_win_len = 27'(FREQ_BASE_CYCLES / 1000);
    endcase
  end

  // Clear beats preload, preload beats counting.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      c1_count_o <= 32'h00000000;
      c1_ovf_p <= 1'b0;
      c1_unf_p <= 1'b0;
    end
    else
    begin
      c1_ovf_p <= 1'b0;
      c1_unf_p <= 1'b0;
      if (c1_freq_mode_i)
      begin
        if (c1_win + 27'h0000001 >= c1_win_len)
        begin
          c1_count_o <= c1_pulses;
        end
      end
      else if (c1_clr_hit)
      begin
        c1_count_o <= 32'h00000000;
      end
      else if (c1_pre_hit)
      begin
        c1_count_o <= c1_preload_i;
      end
      else if (c1_run && c1_step[1])
      begin
        c1_count_o <= c1_count_o + 32'h00000001;
        c1_ovf_p <= (c1_count_o == dhsc_pkg::C1_MAX);
      end
      else if (c1_run && c1_step[0])
      begin
        c1_count_o <= c1_count_o - 32'h00000001;
        c1_unf_p <= (c1_count_o == 32'h00000000);
      end
    end
  end

  // Measurement window; the pulse tally restarts on every window end.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      c1_win <= 27'h0000000;
      c1_pulses <= 32'h00000000;
    end
    else if (!c1_freq_mode_i || c1_win + 27'h0000001 >= c1_win_len)
    begin
      c1_win <= 27'h0000000;
      c1_pulses <= 32'h00000000;
    end
    else
    begin
      c1_win <= c1_win + 27'h0000001;
      if (c1_run && (c1_step != 2'h0))
      begin
        c1_pulses <= c1_pulses + 32'h00000001;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      c1_latch_o <= 32'h00000000;
      c1_ovf_pp <= 1'b0;
      c1_unf_pp <= 1'b0;
    end
    else
    begin
      c1_ovf_pp <= c1_ovf_p;
      c1_unf_pp <= c1_unf_p;
      if (c1_lat_hit)
      begin
        c1_latch_o <= c1_count_o;
      end
    end
  end

  // A new event in the reset cycle keeps its flag set.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      c1_ovf_flag_o <= 1'b0;
      c1_unf_flag_o <= 1'b0;
    end
    else
    begin
      c1_ovf_flag_o <= c1_ovf_p || (c1_ovf_flag_o && !flag_reset_i);
      c1_unf_flag_o <= c1_unf_p || (c1_unf_flag_o && !flag_reset_i);
    end
  end

  // ---------------------------------------------------------------
  // Counter two
  // ---------------------------------------------------------------
  logic c2_ovf_p;
  logic c2_unf_p;
  logic c2_ovf_pp;
  logic c2_unf_pp;
  logic c2_clr_hit;
  logic [1:0] c2_step;

  assign c2_clr_hit = trig_hit(c2_clr_src_i, c2_clr_pol_i,
                               {c2_clr_q_i, c2_unf_p, c2_ovf_p, filt, 1'b0},
                               {q_prev[4], c2_unf_pp, c2_ovf_pp, filt_prev, 1'b0});
  assign c2_step = step(c2_mode_i, filt, filt_prev, ref_tick, c2_dir_q_i);

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      c2_count_o <= 16'h0000;
      c2_ovf_p <= 1'b0;
      c2_unf_p <= 1'b0;
      c2_ovf_pp <= 1'b0;
      c2_unf_pp <= 1'b0;
    end
    else
    begin
      c2_ovf_pp <= c2_ovf_p;
      c2_unf_pp <= c2_unf_p;
      c2_ovf_p <= !c2_clr_hit && c2_step[1] && (c2_count_o == dhsc_pkg::C2_MAX);
      c2_unf_p <= !c2_clr_hit && c2_step[0] && (c2_count_o == 16'h0000);
      if (c2_clr_hit)
      begin
        c2_count_o <= 16'h0000;
      end
      else if (c2_step[1])
      begin
        c2_count_o <= c2_count_o + 16'h0001;
      end
      else if (c2_step[0])
      begin
        c2_count_o <= c2_count_o - 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pulse outputs
  // ---------------------------------------------------------------
  // A phase accumulator advancing by the frequency word each cycle wraps
  // exactly freq times a second, so no divider is needed.
  logic [14:0] duty [2];
  logic [15:0] freq [2];
  logic manual [2];
  logic pwm_q [2];

  assign duty[0] = pwm1_duty_i;
  assign duty[1] = pwm2_duty_i;
  assign freq[0] = pwm1_freq_i;
  assign freq[1] = pwm2_freq_i;
  assign manual[0] = pwm1_manual_i;
  assign manual[1] = pwm2_manual_i;

  for (genvar ch = 0; ch < 2; ch++)
  begin : g_pwm
    logic [26:0] phase;
    logic [26:0] next_phase;
    logic [26:0] thr;
    logic [14:0] duty_c;

    assign duty_c = (duty[ch] > dhsc_pkg::DUTY_FULL) ? dhsc_pkg::DUTY_FULL : duty[ch];
    assign thr = 27'(duty_c * dhsc_pkg::DUTY_SCALE);
    assign next_phase = (phase + 27'(freq[ch]) >= dhsc_pkg::PHASE_WRAP) ?
                        phase + 27'(freq[ch]) - dhsc_pkg::PHASE_WRAP :
                        phase + 27'(freq[ch]);

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
      if (!nrst_i)
      begin
        phase <= dhsc_pkg::PHASE_RST;
        pwm_q[ch] <= 1'b0;
      end
      else if (freq[ch] == 16'h0000)
      begin
        phase <= dhsc_pkg::PHASE_RST;
        pwm_q[ch] <= manual[ch];
      end
      else
      begin
        phase <= next_phase;
        pwm_q[ch] <= (next_phase < thr);
      end
    end
  end

  assign first_pulse_output_ttl_o = pwm_q[0];
  assign first_pulse_output_hv_o = pwm_q[0];
  assign second_pulse_output_ttl_o = pwm_q[1];
  assign second_pulse_output_hv_o = pwm_q[1];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_ref_tick;
    @(posedge clk_i) disable iff (!nrst_i)
    ref_tick |=> !ref_tick [*8] ##1 !ref_tick ##1 ref_tick;
  endproperty
  a_ref_tick: assert property (p_ref_tick) else $error("reference tick not every 10 cycles");

  property p_clear;
    @(posedge clk_i) disable iff (!nrst_i)
    c1_clr_hit |=> c1_count_o == 32'h00000000;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not zero counter one");

  property p_preload;
    @(posedge clk_i) disable iff (!nrst_i)
    c1_pre_hit && !c1_clr_hit |=> c1_count_o == $past(c1_preload_i);
  endproperty
  a_preload: assert property (p_preload) else $error("preload value not loaded");

  property p_latch;
    @(posedge clk_i) disable iff (!nrst_i)
    c1_lat_hit |=> c1_latch_o == $past(c1_count_o);
  endproperty
  a_latch: assert property (p_latch) else $error("latch missed accumulator");

  property p_latch_hold;
    @(posedge clk_i) disable iff (!nrst_i)
    !c1_lat_hit |=> $stable(c1_latch_o);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched value moved");

  property p_disable;
    @(posedge clk_i) disable iff (!nrst_i)
    c1_dis_hit && !c1_freq_mode_i && !c1_clr_hit && !c1_pre_hit |=> $stable(c1_count_o);
  endproperty
  a_disable: assert property (p_disable) else $error("counted while disabled");

  property p_flag_hold;
    @(posedge clk_i) disable iff (!nrst_i)
    c1_ovf_flag_o && !flag_reset_i |=> c1_ovf_flag_o;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("overflow flag dropped");

  property p_ovf_set;
    @(posedge clk_i) disable iff (!nrst_i)
    c1_ovf_p |-> c1_count_o == 32'h00000000 ##1 c1_ovf_flag_o;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow not on wrap to zero");

  property p_full_duty;
    @(posedge clk_i) disable iff (!nrst_i)
    pwm1_freq_i != 16'h0000 && pwm1_duty_i >= dhsc_pkg::DUTY_FULL |=> first_pulse_output_ttl_o;
  endproperty
  a_full_duty: assert property (p_full_duty) else $error("full duty not high");

  property p_manual;
    @(posedge clk_i) disable iff (!nrst_i)
    pwm2_freq_i == 16'h0000 |=> second_pulse_output_hv_o == $past(pwm2_manual_i);
  endproperty
  a_manual: assert property (p_manual) else $error("manual control not followed");

  c_ovf: cover property (@(posedge clk_i) disable iff (!nrst_i) $rose(c1_ovf_flag_o));
  c_latch: cover property (@(posedge clk_i) disable iff (!nrst_i) c1_lat_hit);
  c_c2_clear: cover property (@(posedge clk_i) disable iff (!nrst_i) c2_clr_hit);
  c_pwm_edge: cover property (@(posedge clk_i) disable iff (!nrst_i)
                              $rose(first_pulse_output_ttl_o));

endmodule

// [bench/dhsc_pulse_src.sv]
`timescale 1ns/1ps
module dhsc_pulse_src (
  input wire logic clk_i,
  output logic ext1_o,
  output logic ext2_o,
  output logic ext3_o
);
  // Sources rest low; each pulse is 4 cycles high and 4 low, passed only with the filter off
  initial {ext1_o, ext2_o, ext3_o} = 3'h0;
  task automatic pulse(input int ch, input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      #1;
      if (ch == 1) ext1_o = 1'b1; else ext2_o = 1'b1;
      repeat (4) @(posedge clk_i);
      #1;
      if (ch == 1) ext1_o = 1'b0; else ext2_o = 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
    end
  endtask
endmodule

// [bench/dhsc_top_tb.sv]
`timescale 1ns/1ps
module dhsc_top_tb;
  logic clk_i, nrst_i, c1_freq_mode_i, c1_dis_q_i, c1_lat_q_i, c1_pre_q_i, c1_clr_q_i;
  logic c1_dir_q_i, flag_reset_i, c2_clr_q_i, c2_dir_q_i, pwm1_manual_i, pwm2_manual_i;
  wire ext1_i, ext2_i, ext3_i;
  dhsc_pkg::dhsc_filt_e ext1_filt_i, ext2_filt_i, ext3_filt_i;
  dhsc_pkg::dhsc_mode_e c1_mode_i, c2_mode_i;
  dhsc_pkg::dhsc_src_e c1_dis_src_i, c1_lat_src_i, c1_pre_src_i, c1_clr_src_i, c2_clr_src_i;
  dhsc_pkg::dhsc_pol_e c1_dis_pol_i, c1_lat_pol_i, c1_pre_pol_i, c1_clr_pol_i, c2_clr_pol_i;
  logic [1:0] c1_period_sel_i;
  logic [31:0] c1_preload_i, c1_count_o, c1_latch_o;
  logic [14:0] pwm1_duty_i, pwm2_duty_i;
  logic [15:0] pwm1_freq_i, pwm2_freq_i, c2_count_o;
  logic [2:0] ext_state_o;
  logic c1_ovf_flag_o, c1_unf_flag_o, first_pulse_output_ttl_o, first_pulse_output_hv_o;
  logic second_pulse_output_ttl_o, second_pulse_output_hv_o;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;

  dhsc_pulse_src src_u (.clk_i, .ext1_o(ext1_i), .ext2_o(ext2_i), .ext3_o(ext3_i));
  dhsc_top #(.FREQ_BASE_CYCLES(1000)) dut_u (.clk_i, .nrst_i, .ext1_i, .ext2_i, .ext3_i,
    .ext1_filt_i, .ext2_filt_i, .ext3_filt_i, .c1_freq_mode_i, .c1_mode_i, .c1_period_sel_i,
    .c1_dis_src_i, .c1_dis_pol_i, .c1_lat_src_i, .c1_lat_pol_i, .c1_pre_src_i, .c1_pre_pol_i,
    .c1_clr_src_i, .c1_clr_pol_i, .c1_dis_q_i, .c1_lat_q_i, .c1_pre_q_i, .c1_clr_q_i,
    .c1_dir_q_i, .c1_preload_i, .flag_reset_i, .c2_mode_i, .c2_clr_src_i, .c2_clr_pol_i,
    .c2_clr_q_i, .c2_dir_q_i, .pwm1_duty_i, .pwm1_freq_i, .pwm1_manual_i, .pwm2_duty_i,
    .pwm2_freq_i, .pwm2_manual_i, .ext_state_o, .c1_count_o, .c1_latch_o, .c1_ovf_flag_o,
    .c1_unf_flag_o, .c2_count_o, .first_pulse_output_ttl_o, .first_pulse_output_hv_o,
    .second_pulse_output_ttl_o, .second_pulse_output_hv_o);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic clear_c1;
    c1_clr_q_i = 1'b1;
    tick(3);
    c1_clr_q_i = 1'b0;
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_count;
    src_u.pulse(1, 3);
    src_u.pulse(2, 2);
    tick(4);
    check(c1_count_o, 32'h00000005);
    check(32'(c2_count_o), 32'h00000005);
    c1_mode_i = dhsc_pkg::MODE_UPDN;
    src_u.pulse(1, 3);
    src_u.pulse(2, 1);
    tick(4);
    check(c1_count_o, 32'h00000007);
    src_u.ext3_o = 1'b1;
    tick(3);
    check(32'(ext_state_o), 32'h00000004);
    check(32'(c2_count_o), 32'h00000000);
    src_u.ext3_o = 1'b0;
    $display("test count done");
  endtask

  task automatic t_trig;
    clear_c1();
    check(c1_count_o, 32'h00000000);
    c1_pre_q_i = 1'b1;
    tick(3);
    c1_pre_q_i = 1'b0;
    check(c1_count_o, 32'h00ABCDEF);
    c1_lat_q_i = 1'b1;
    tick(3);
    c1_lat_q_i = 1'b0;
    check(c1_latch_o, 32'h00ABCDEF);
    c1_dis_q_i = 1'b1;
    src_u.pulse(1, 2);
    tick(4);
    check(c1_count_o, 32'h00ABCDEF);
    c1_dis_q_i = 1'b0;
    src_u.pulse(1, 2);
    tick(4);
    check(c1_count_o, 32'h00ABCDF1);
    check(c1_latch_o, 32'h00ABCDEF);
    $display("test trig done");
  endtask

  task automatic t_wrap;
    clear_c1();
    c1_mode_i = dhsc_pkg::MODE_DOWN;
    src_u.pulse(1, 1);
    tick(4);
    check(c1_count_o, 32'hFFFFFFFF);
    tick(20);
    check(32'({c1_unf_flag_o, c1_ovf_flag_o}), 32'h00000002);
    c1_mode_i = dhsc_pkg::MODE_UP;
    src_u.pulse(1, 1);
    tick(4);
    check(c1_count_o, 32'h00000000);
    flag_reset_i = 1'b1;
    tick(1);
    flag_reset_i = 1'b0;
    tick(2);
    check(32'({c1_unf_flag_o, c1_ovf_flag_o}), 32'h00000000);
    c1_mode_i = dhsc_pkg::MODE_CLKDIR_Q;
    c1_dir_q_i = 1'b1;
    src_u.pulse(1, 2);
    c1_dir_q_i = 1'b0;
    src_u.pulse(1, 1);
    tick(4);
    check(c1_count_o, 32'h00000001);
    c1_mode_i = dhsc_pkg::MODE_CLKDIR_IN;
    src_u.ext2_o = 1'b1;
    src_u.pulse(1, 2);
    src_u.ext2_o = 1'b0;
    tick(4);
    check(c1_count_o, 32'h00000003);
    $display("test wrap done");
  endtask

  task automatic t_int_freq;
    c1_mode_i = dhsc_pkg::MODE_INTERNAL;
    clear_c1();
    tick(100);
    check(32'(c1_count_o >= 9 && c1_count_o <= 11), 32'h00000001);
    c1_mode_i = dhsc_pkg::MODE_UP;
    c1_freq_mode_i = 1'b1;
    src_u.pulse(1, 300);
    check(32'(c1_count_o >= 124 && c1_count_o <= 125), 32'h00000001);
    $display("test int_freq done");
  endtask

  task automatic t_pwm;
    logic [31:0] h1;
    logic [31:0] h2;
    logic [31:0] ne;
    {h1, h2, ne} = '0;
    pwm1_freq_i = 16'h2710;
    pwm1_duty_i = 15'h3E80;
    pwm2_freq_i = 16'h2710;
    pwm2_duty_i = 15'h1F40;
    tick(10);
    repeat (10000)
    begin
      h1 += first_pulse_output_ttl_o;
      h2 += second_pulse_output_ttl_o;
      ne += (first_pulse_output_ttl_o !== first_pulse_output_hv_o);
      ne += (second_pulse_output_ttl_o !== second_pulse_output_hv_o);
      tick(1);
    end
    check(h1, 32'h00001388);
    check(h2, 32'h000009C4);
    check(ne, 32'h00000000);
    pwm2_freq_i = 16'h0000;
    pwm2_manual_i = 1'b1;
    pwm1_duty_i = 15'h7D00;
    tick(5);
    h2 = '0;
    repeat (20)
    begin
      h2 += first_pulse_output_hv_o;
      tick(1);
    end
    check(h2, 32'h00000014);
    check(32'(second_pulse_output_hv_o), 32'h00000001);
    $display("test pwm done");
  endtask

  initial
  begin
    nrst_i = 1'b0;
    {c1_freq_mode_i, c1_dis_q_i, c1_lat_q_i, c1_pre_q_i, c1_clr_q_i, c1_dir_q_i} = '0;
    {flag_reset_i, c2_clr_q_i, c2_dir_q_i, pwm1_manual_i, pwm2_manual_i} = '0;
    ext1_filt_i = dhsc_pkg::FILT_OFF;
    ext2_filt_i = dhsc_pkg::FILT_OFF;
    ext3_filt_i = dhsc_pkg::FILT_OFF;
    c1_mode_i = dhsc_pkg::MODE_UP;
    c2_mode_i = dhsc_pkg::MODE_UP;
    c1_dis_src_i = dhsc_pkg::SRC_Q;
    c1_lat_src_i = dhsc_pkg::SRC_Q;
    c1_pre_src_i = dhsc_pkg::SRC_Q;
    c1_clr_src_i = dhsc_pkg::SRC_Q;
    c2_clr_src_i = dhsc_pkg::SRC_IN3;
    c1_dis_pol_i = dhsc_pkg::POL_HIGH;
    c1_lat_pol_i = dhsc_pkg::POL_RISE;
    c1_pre_pol_i = dhsc_pkg::POL_HIGH;
    c1_clr_pol_i = dhsc_pkg::POL_RISE;
    c2_clr_pol_i = dhsc_pkg::POL_RISE;
    c1_period_sel_i = 2'h0;
    c1_preload_i = 32'h00ABCDEF;
    {pwm1_duty_i, pwm2_duty_i, pwm1_freq_i, pwm2_freq_i} = '0;
    tick(5);
    nrst_i = 1'b1;
    tick(2);
    t_count();
    t_trig();
    t_wrap();
    t_int_freq();
    t_pwm();
    close_out();
  end
endmodule
